// >>> rtl/qdcd_pkg.sv
// Purpose: Constants for the quad DAC serial command decoder
// Assumes: 24-bit command frames, MSB first
// Notes: Function register is 6 bits wide
package qdcd_pkg;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam int RW_POS = 23;
  localparam int ZERO_POS = 22;
  localparam int REG_HI = 21;
  localparam int REG_LO = 19;
  localparam int ADDR_HI = 18;
  localparam int ADDR_LO = 16;
  localparam int DATA_HI = 15;
  // ----------------------------------------
  // Register select codes
  // ----------------------------------------
  localparam logic [2:0] SEL_FUNC = 3'h0;
  localparam logic [2:0] SEL_DATA = 3'h2;
  localparam logic [2:0] SEL_CGAIN = 3'h3;
  localparam logic [2:0] SEL_FGAIN = 3'h4;
  localparam logic [2:0] SEL_OFFS = 3'h5;
  // ----------------------------------------
  // Channel address codes and function addresses
  // ----------------------------------------
  localparam logic [2:0] CH_A = 3'h0;
  localparam logic [2:0] CH_B = 3'h1;
  localparam logic [2:0] CH_C = 3'h2;
  localparam logic [2:0] CH_D = 3'h3;
  localparam logic [2:0] CH_ALL = 3'h4;
  localparam logic [2:0] FN_NOP = 3'h0;
  localparam logic [2:0] FN_CTRL = 3'h1;
  localparam logic [2:0] FN_CLEAR = 3'h4;
  localparam logic [2:0] FN_LOAD = 3'h5;
  // ----------------------------------------
  // Function register fields and reset value
  // ----------------------------------------
  localparam int FB_LGND = 5;
  localparam int FB_P1DIR = 4;
  localparam int FB_P1VAL = 3;
  localparam int FB_P0DIR = 2;
  localparam int FB_P0VAL = 1;
  localparam int FB_SODIS = 0;
  localparam logic [5:0] FUNC_RST = 6'h00;
endpackage

// >>> rtl/qdcd_top.sv
// Purpose: Serial command decoder and function register of a quad DAC
// Assumes: Link pins asynchronous, sampled at 25 MHz via two flops
// Notes: Analog registers are reported as select strobes only
//
// Contract
// - Bit 23 is read/write flag
// - Bit 22 zero; select, address, data fields
// - Decode register select codes
// - Decode channel address codes
// - Select 000 uses address for function
// - Address 000 is no-operation
// - Address 001 stores control bits 5..0
// - Local ground offset enable, reset cleared
// - Direction bit sets output, reset input
// - Output pin drives last written value
// - Input pin value bit reads level
// - Input pin ignores written value bit
// - Serial output disable bit, reset enabled
// - Address 100 clears all outputs
// - Address 101 loads all outputs
// - Act only on exactly 24 falling edges
// - Read data shifted out next frame
// - Output changes on rising clock edge
`timescale 1ns/100ps
module qdcd_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic sync_n_i,
  input wire logic sdin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  // Auxiliary pins
  input wire logic aux_pin_zero_i,
  output logic aux_pin_zero_o,
  output logic aux_pin_zero_oe_o,
  input wire logic aux_pin_one_i,
  output logic aux_pin_one_o,
  output logic aux_pin_one_oe_o,
  // Ground offset enable, decoded command strobes and write fields
  output logic lgnd_adj_en_o,
  output logic clear_all_o,
  output logic load_all_o,
  output logic reg_wr_o,
  output logic [2:0] reg_sel_o,
  output logic [3:0] chan_mask_o,
  output logic [15:0] reg_data_o,
  // Readback data from analog registers
  input wire logic [15:0] rd_data_i
);
  // ----------------------------------------
  // Synchronisers and edge detect
  // ----------------------------------------
  logic [1:0] sclk_s_r, sync_s_r, sdin_s_r, p0_s_r, p1_s_r;
  logic sclk_d_r, sync_d_r;
  always_ff @(posedge core_clk_i) begin
    sclk_s_r <= {sclk_s_r[0], sclk_i};
    sync_s_r <= {sync_s_r[0], sync_n_i};
    sdin_s_r <= {sdin_s_r[0], sdin_i};
    p0_s_r <= {p0_s_r[0], aux_pin_zero_i};
    p1_s_r <= {p1_s_r[0], aux_pin_one_i};
    sclk_d_r <= sclk_s_r[1];
    sync_d_r <= sync_s_r[1];
  end
  wire sclk_fall = sclk_d_r & ~sclk_s_r[1];
  wire sclk_rise = ~sclk_d_r & sclk_s_r[1];
  wire sync_rise = ~sync_d_r & sync_s_r[1];
  wire sync_fall = sync_d_r & ~sync_s_r[1];
  wire in_frame = ~sync_s_r[1];

  // ----------------------------------------
  // Input shift register and edge count
  // ----------------------------------------
  logic [23:0] shift_r;
  logic [4:0] cnt_r;
  logic over_r;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || sync_fall) begin
      cnt_r <= 5'h00;
      over_r <= 1'b0;
    end else if (in_frame && sclk_fall) begin
      if (cnt_r == qdcd_pkg::FRAME_LAST + 5'h01) over_r <= 1'b1;
      else cnt_r <= cnt_r + 5'h01;
    end
    if (sys_rst_i) shift_r <= 24'h000000;
    else if (in_frame && sclk_fall) shift_r <= {shift_r[22:0], sdin_s_r[1]};
  end
  wire frame_ok = sync_rise && !over_r && (cnt_r == qdcd_pkg::FRAME_LAST + 5'h01);

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire rd_req = shift_r[qdcd_pkg::RW_POS];
  wire zero_ok = ~shift_r[qdcd_pkg::ZERO_POS];
  wire [2:0] sel = shift_r[qdcd_pkg::REG_HI:qdcd_pkg::REG_LO];
  wire [2:0] adr = shift_r[qdcd_pkg::ADDR_HI:qdcd_pkg::ADDR_LO];
  wire [15:0] dat = shift_r[qdcd_pkg::DATA_HI:0];

  function automatic logic [3:0] qdcd_chan(input logic [2:0] a);
    case (a)
      qdcd_pkg::CH_A: qdcd_chan = 4'h1;
      qdcd_pkg::CH_B: qdcd_chan = 4'h2;
      qdcd_pkg::CH_C: qdcd_chan = 4'h4;
      qdcd_pkg::CH_D: qdcd_chan = 4'h8;
      qdcd_pkg::CH_ALL: qdcd_chan = 4'hf;
      default: qdcd_chan = 4'h0;
    endcase
  endfunction

  wire is_func = (sel == qdcd_pkg::SEL_FUNC);
  wire is_anreg = (sel == qdcd_pkg::SEL_DATA) || (sel == qdcd_pkg::SEL_CGAIN) ||
    (sel == qdcd_pkg::SEL_FGAIN) || (sel == qdcd_pkg::SEL_OFFS);
  wire [3:0] chmask = qdcd_chan(adr);
  wire go = frame_ok && zero_ok;
  wire wr_go = go && !rd_req;
  wire fn_ctrl = wr_go && is_func && (adr == qdcd_pkg::FN_CTRL);
  wire fn_clear = wr_go && is_func && (adr == qdcd_pkg::FN_CLEAR);
  wire fn_load = wr_go && is_func && (adr == qdcd_pkg::FN_LOAD);
  // Nop and unlisted codes reach no state below
  wire an_wr = wr_go && is_anreg && (chmask != 4'h0);

  // ----------------------------------------
  // Function register
  // ----------------------------------------
  logic [5:0] func_r;
  logic [5:0] func_nxt;
  always_comb begin
    func_nxt = func_r;
    if (fn_ctrl) begin
      func_nxt = dat[5:0];
      if (!dat[qdcd_pkg::FB_P1DIR]) func_nxt[qdcd_pkg::FB_P1VAL] = func_r[qdcd_pkg::FB_P1VAL];
      if (!dat[qdcd_pkg::FB_P0DIR]) func_nxt[qdcd_pkg::FB_P0VAL] = func_r[qdcd_pkg::FB_P0VAL];
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) func_r <= qdcd_pkg::FUNC_RST;
    else func_r <= func_nxt;
  end
  // Readback value: input pins show live level
  wire [5:0] func_view = {func_r[5:4],
    func_r[qdcd_pkg::FB_P1DIR] ? func_r[qdcd_pkg::FB_P1VAL] : p1_s_r[1],
    func_r[2],
    func_r[qdcd_pkg::FB_P0DIR] ? func_r[qdcd_pkg::FB_P0VAL] : p0_s_r[1],
    func_r[0]};

  // ----------------------------------------
  // Readback and serial output
  // ----------------------------------------
  logic rd_pend_r;
  logic [23:0] out_r;
  logic so_bit_r;
  wire rd_go = go && rd_req;
  wire [15:0] rd_word = is_func ? {10'h000, func_view} : rd_data_i;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rd_pend_r <= 1'b0;
      out_r <= 24'h000000;
      so_bit_r <= 1'b0;
    end else begin
      if (sync_rise) rd_pend_r <= rd_go;
      if (rd_go) out_r <= {8'h00, rd_word};
      else if (sync_fall && !rd_pend_r) out_r <= 24'h000000;
      if (in_frame && sclk_rise) begin
        so_bit_r <= out_r[23];
        out_r <= {out_r[22:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      serial_out_pin_o <= 1'b0;
      serial_out_pin_oe_o <= 1'b0;
      aux_pin_zero_o <= 1'b0;
      aux_pin_zero_oe_o <= 1'b0;
      aux_pin_one_o <= 1'b0;
      aux_pin_one_oe_o <= 1'b0;
      lgnd_adj_en_o <= 1'b0;
      clear_all_o <= 1'b0;
      load_all_o <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_sel_o <= 3'h0;
      chan_mask_o <= 4'h0;
      reg_data_o <= 16'h0000;
    end else begin
      serial_out_pin_o <= so_bit_r;
      serial_out_pin_oe_o <= ~func_r[qdcd_pkg::FB_SODIS];
      aux_pin_zero_o <= func_r[qdcd_pkg::FB_P0VAL];
      aux_pin_zero_oe_o <= func_r[qdcd_pkg::FB_P0DIR];
      aux_pin_one_o <= func_r[qdcd_pkg::FB_P1VAL];
      aux_pin_one_oe_o <= func_r[qdcd_pkg::FB_P1DIR];
      lgnd_adj_en_o <= func_r[qdcd_pkg::FB_LGND];
      clear_all_o <= fn_clear;
      load_all_o <= fn_load;
      reg_wr_o <= an_wr;
      if (an_wr) begin
        reg_sel_o <= sel;
        chan_mask_o <= chmask;
        reg_data_o <= dat;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ctrl_write_lgnd: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fn_ctrl |-> ##2 lgnd_adj_en_o == $past(dat[qdcd_pkg::FB_LGND], 2))
    else $error("ground offset enable not stored");
  a_clear_pulse: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    clear_all_o |-> $past(frame_ok) && $past(sel) == qdcd_pkg::SEL_FUNC &&
      $past(adr) == qdcd_pkg::FN_CLEAR)
    else $error("clear without clear command");
  a_load_pulse: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    load_all_o |-> $past(frame_ok) && $past(adr) == qdcd_pkg::FN_LOAD && !$past(rd_req))
    else $error("load without load command");
  // Short or long frames must leave the function register and every strobe alone
  a_frame_count: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (sync_rise && (over_r || cnt_r != qdcd_pkg::FRAME_LAST + 5'h01)) |=>
      $stable(func_r) && !clear_all_o && !load_all_o && !reg_wr_o)
    else $error("frame with wrong edge count acted on");
  a_input_ignore: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (fn_ctrl && !dat[qdcd_pkg::FB_P0DIR]) |=>
      func_r[qdcd_pkg::FB_P0VAL] == $past(func_r[qdcd_pkg::FB_P0VAL]))
    else $error("input pin value overwritten");
  a_pin_drive: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (fn_ctrl && dat[qdcd_pkg::FB_P0DIR]) |-> ##2
      aux_pin_zero_oe_o && aux_pin_zero_o == $past(dat[qdcd_pkg::FB_P0VAL], 2))
    else $error("output pin not driving value");
  a_nop_stable: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (go && is_func && adr == qdcd_pkg::FN_NOP) |=>
      $stable(func_r) && !clear_all_o && !load_all_o)
    else $error("nop changed state");
  // First edge after reset still shows the reset value of the enable
  a_serial_out_enable: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) |-> serial_out_pin_oe_o == !$past(func_r[qdcd_pkg::FB_SODIS]))
    else $error("serial output enable wrong");
  a_serial_out_edge: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(so_bit_r) |-> $past(sclk_rise))
    else $error("serial output changed off rising edge");
  c_ctrl_write: cover property (@(posedge core_clk_i) fn_ctrl);
  c_read_req: cover property (@(posedge core_clk_i) rd_go);
  c_clear_cmd: cover property (@(posedge core_clk_i) fn_clear);
  c_an_write: cover property (@(posedge core_clk_i) an_wr);
endmodule // qdcd_top

// >>> tb/qdcd_host_model.sv
// Purpose: Serial host model driving command frames
// Assumes: Link clock idles low, high 200 ns, low 120 ns
// Notes: Released data line reads as inverse of last bit
`timescale 1ns/100ps
module qdcd_host_model (
  // Link
  output logic sclk_o,
  output logic sync_n_o,
  output logic sdin_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    sdin_o = 1'b0;
  end
  // One frame, falls sets the edge count
  task automatic frame(input logic [23:0] w, input int falls, output logic [23:0] cap);
    cap = 24'h0;
    sync_n_o = 1'b0;
    for (int i = 0; i < falls; i++) begin
      #120 sdin_o = (i < 24) ? w[23 - i] : 1'b0;
      sclk_o = 1'b1;
      #200 sclk_o = 1'b0;
      cap = {cap[22:0], so_oe_i ? so_i : ~cap[0]};
    end
    #120 sync_n_o = 1'b1;
    sdin_o = ~sdin_o;
    #200;
  endtask
endmodule // qdcd_host_model

// >>> tb/qdcd_top_tb_top.sv
// Purpose: Bench for the quad DAC command decoder
// Assumes: Host model frames at 320 ns link period
// Notes: Pulses counted, outputs checked after each frame except read requests
`timescale 1ns/100ps
module qdcd_top_tb_top;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sclk, sync_n, sdin, so_pin, so_oe, p0_o, p0_oe, p1_o, p1_oe, lgnd, clr, ld, wr;
  logic p0_ext = 1'b1;
  logic p1_ext = 1'b0;
  logic [2:0] sel;
  logic [3:0] mask;
  logic [15:0] rdat;
  logic [15:0] rd_data = 16'ha5c3;
  logic [23:0] cap;
  int bad_count = 0;
  int n_tests = 0;
  int n_clr = 0;
  int n_ld = 0;
  int n_wr = 0;
  wire p0_w = p0_oe ? p0_o : p0_ext;
  wire p1_w = p1_oe ? p1_o : p1_ext;
  always #20 core_clk_i = ~core_clk_i;
  // Pulses counted mid-cycle, where they are settled
  always @(negedge core_clk_i) begin
    if (clr === 1'b1) n_clr++;
    if (ld === 1'b1) n_ld++;
    if (wr === 1'b1) n_wr++;
  end
  qdcd_host_model u_host (.sclk_o(sclk), .sync_n_o(sync_n), .sdin_o(sdin), .so_i(so_pin),
    .so_oe_i(so_oe));
  qdcd_top u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
    .sync_n_i(sync_n), .sdin_i(sdin), .serial_out_pin_o(so_pin), .serial_out_pin_oe_o(so_oe),
    .aux_pin_zero_i(p0_w), .aux_pin_zero_o(p0_o), .aux_pin_zero_oe_o(p0_oe),
    .aux_pin_one_i(p1_w), .aux_pin_one_o(p1_o), .aux_pin_one_oe_o(p1_oe),
    .lgnd_adj_en_o(lgnd), .clear_all_o(clr), .load_all_o(ld), .reg_wr_o(wr),
    .reg_sel_o(sel), .chan_mask_o(mask), .reg_data_o(rdat), .rd_data_i(rd_data));
  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [23:0] w, input int f = 24);
    @(negedge core_clk_i);
    u_host.frame(w, f, cap);
    repeat (8) @(negedge core_clk_i);
  endtask
  function automatic logic [31:0] snap();
    return {3'h0, lgnd, p0_oe, p0_o, p1_oe, p1_o, so_oe, sel, mask, rdat};
  endfunction
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_ctrl();
    send(24'h01ffee);
    chk({lgnd, p1_oe, p1_o, p0_oe, p0_o}, 5'h13);
    send(24'h810000);
    send(24'h000000);
    chk(cap, 24'h000026);
    p1_ext = 1'b1;
    send(24'h810000);
    send(24'h000000);
    chk(cap, 24'h00002e);
  endtask
  task automatic t_fn();
    int c0, l0;
    for (int k = 0; k < 2; k++) begin
      c0 = n_clr;
      l0 = n_ld;
      send({5'h00, (k == 1) ? qdcd_pkg::FN_LOAD : qdcd_pkg::FN_CLEAR, 16'hffff});
      chk(n_clr - c0, 32'(1 - k));
      chk(n_ld - l0, 32'(k));
    end
  endtask
  task automatic t_ana();
    logic [2:0] s;
    logic [15:0] d;
    int w0;
    for (int j = 0; j < 4; j++) begin
      for (int c = 0; c < 5; c++) begin
        s = 3'(j + 2);
        d = 16'h8000 | 16'(j * 5 + c);
        w0 = n_wr;
        send({2'b00, s, 3'(c), d});
        chk(n_wr - w0, 1);
        chk({sel, mask, rdat}, {s, (c == 4) ? 4'hf : 4'(1 << c), d});
      end
    end
    w0 = n_wr;
    send({2'b10, qdcd_pkg::SEL_DATA, qdcd_pkg::CH_B, 16'h0000});
    send(24'h000000);
    chk(cap, {8'h00, rd_data});
    chk(n_wr - w0, 0);
  endtask
  task automatic t_ref();
    logic [23:0] ws [8] = '{24'h410000, 24'h010000, 24'h010000, 24'h090000,
      24'h020000, 24'h15ffff, 24'h00ffff, 24'h07ffff};
    int fs [8] = '{24, 23, 25, 24, 24, 24, 24, 24};
    logic [31:0] s0;
    int p0;
    for (int i = 0; i < 8; i++) begin
      s0 = snap();
      p0 = n_clr + n_ld + n_wr;
      send(ws[i], fs[i]);
      chk(snap(), s0);
      chk(n_clr + n_ld + n_wr, p0);
    end
  endtask
  task automatic t_sod();
    send(24'h010001);
    chk({lgnd, so_oe}, 2'b00);
    send(24'h010000);
    chk({lgnd, so_oe}, 2'b01);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    chk({lgnd, p0_oe, p1_oe, so_oe}, 4'h1);
    t_ctrl();
    t_fn();
    t_ana();
    t_ref();
    t_sod();
    give_verdict();
  end
  initial begin
    #2000000;
    bad_count++;
    give_verdict();
  end
endmodule // qdcd_top_tb_top
